// File: core/dpr_pkg.sv
package dpr_pkg;
  localparam int TXN_PER_PKT      = 16;
  localparam int PAYLOAD_BYTES    = 32;
  localparam int TIMESLICE_US     = 50;
  localparam int CLK_FREQ_MHZ     = 125;
  localparam int TIMESLICE_CYCLES = TIMESLICE_US * CLK_FREQ_MHZ;

  localparam logic [11:0] REG_CTRL_OFS   = 12'h000;
  localparam logic [11:0] REG_STATUS_OFS = 12'h004;
  localparam logic [11:0] REG_MASK_OFS   = 12'h008;
  localparam logic [11:0] REG_STATE_OFS  = 12'h00C;
  localparam logic [11:0] REG_COUNT_OFS  = 12'h010;

  localparam int          CTRL_ENABLE_BIT = 0;
  localparam logic [0:0]  CTRL_RESET_VAL  = 1'h0;
  localparam logic [7:0]  MASK_RESET_VAL  = 8'h00;

  // exception bit positions
  localparam int EXC_MEM_FAULT   = 0;
  localparam int EXC_UNSUPPORTED = 1;
  localparam int EXC_BAD_PROCESS = 2;
  localparam int EXC_BAD_ROUTE   = 3;
  localparam int EXC_ALREADY_OPEN = 4;
  localparam int EXC_EVENT_IRQ   = 5;
  localparam int EXC_QUEUE_OVF   = 6;
  localparam int EXC_RETRY_EXHAUSTED = 7;
  localparam int EXC_COUNT       = 8;

  typedef struct packed {
    logic        remote;
    logic        secure;
    logic [7:0]  fail_count;
    logic [15:0] byte_count;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
  } dpr_desc_type;

  typedef enum logic [1:0] {
    TXN_OPEN  = 2'b00,
    TXN_BLOCK = 2'b01,
    TXN_NULL  = 2'b10,
    TXN_END   = 2'b11
  } dpr_txn_kind_type;

  typedef struct packed {
    dpr_txn_kind_type kind;
    logic             ack_request_flag;
    logic             local_copy;
    logic [5:0]       len;
    logic [31:0]      src_addr;
    logic [31:0]      dst_addr;
  } dpr_txn_type;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_OPEN    = 4'b0001,
    ST_SEND    = 4'b0010,
    ST_NULL    = 4'b0011,
    ST_WAIT    = 4'b0100,
    ST_CLOSE   = 4'b0101,
    ST_DECIDE  = 4'b0110,
    ST_REQUEUE = 4'b0111,
    ST_LOCAL   = 4'b1000
  } dpr_state_type;
endpackage : dpr_pkg

// File: core/dpr_timeslice.sv
`timescale 1ns/1ps
module dpr_timeslice
  import dpr_pkg::*;
#(
  parameter int PERIOD_CYCLES = TIMESLICE_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic restart,
  output logic      expired
);
  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (restart) begin
      cnt_d = '0;
    end else if (cnt_q != LAST) begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == LAST);
endmodule : dpr_timeslice

// File: core/dpr_exc_status.sv
`timescale 1ns/1ps
module dpr_exc_status
  import dpr_pkg::*;
#(
  parameter int N = EXC_COUNT
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // events and software
  input  wire logic [N-1:0] set_evt,
  input  wire logic         rd_clear,
  input  wire logic [N-1:0] mask,
  output logic [N-1:0]      status,
  output logic              irq
);
  logic [N-1:0] st_q;
  logic [N-1:0] st_d;

  for (genvar i = 0; i < N; i++) begin : g_bit
    always_comb begin
      st_d[i] = st_q[i];
      if (rd_clear) begin
        st_d[i] = 1'b0;
      end
      // set beats read clear
      if (set_evt[i]) begin
        st_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q;
  assign irq    = |(st_q & mask);
endmodule : dpr_exc_status

// File: core/dpr_engine.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module dpr_engine
  import dpr_pkg::*;
#(
  parameter int TIMESLICE_CYC = TIMESLICE_CYCLES
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // descriptor queue
  input  wire logic         desc_valid,
  input  wire dpr_desc_type desc,
  output logic              desc_ready,
  // requeue to queue tail
  output logic              requeue_valid,
  output dpr_desc_type      requeue_desc,
  input  wire logic         requeue_ready,
  // network outputter
  output logic              txn_valid,
  output dpr_txn_type       txn,
  input  wire logic         txn_ready,
  input  wire logic         ack_valid,
  input  wire logic         ack_is_nack,
  // exceptions
  input  wire logic [6:0]   exc_event,
  output logic              desc_done,
  output logic              irq
);
  dpr_state_type state_q;
  dpr_state_type state_d;
  dpr_desc_type  cur_q;
  dpr_desc_type  cur_d;
  dpr_desc_type  snap_q;
  dpr_desc_type  snap_d;
  dpr_txn_type   txn_q;
  dpr_txn_type   txn_d;
  logic          txn_valid_q;
  logic          txn_valid_d;
  logic          rq_valid_q;
  logic          rq_valid_d;
  logic [4:0]    sent_q;
  logic [4:0]    sent_d;
  logic          ack_seen_q;
  logic          ack_seen_d;
  logic          nack_q;
  logic          nack_d;
  logic          done_q;
  logic          done_d;
  logic          exhaust_q;
  logic          exhaust_d;
  logic [15:0]   pkt_cnt_q;
  logic [15:0]   pkt_cnt_d;
  logic          enable_q;
  logic          enable_d;
  logic [7:0]    mask_q;
  logic [7:0]    mask_d;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;
  logic          slot_free;
  logic          restart;
  logic          expired;
  logic [5:0]    chunk;
  logic          take;
  logic          pkt_full;
  logic          stop_normal;
  logic          stop_secure;
  logic          setup;
  logic          access;
  logic          hit;
  logic          status_rd;
  logic [7:0]    status;
  logic [7:0]    exc_set;

  dpr_timeslice #(
    .PERIOD_CYCLES (TIMESLICE_CYC)
  ) u_timeslice (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (restart),
    .expired (expired)
  );

  assign exc_set = {exhaust_q, exc_event};

  dpr_exc_status #(
    .N (EXC_COUNT)
  ) u_exc_status (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_evt  (exc_set),
    .rd_clear (status_rd),
    .mask     (mask_q),
    .status   (status),
    .irq      (irq)
  );

  assign slot_free = !txn_valid_q || txn_ready;
  // take only when idle and enabled
  assign take      = (state_q == ST_IDLE) && enable_q && desc_valid;
  assign restart   = take;
  assign chunk = (cur_q.byte_count >= 16'(PAYLOAD_BYTES)) ?
                 6'(PAYLOAD_BYTES) : cur_q.byte_count[5:0];
  assign pkt_full = (sent_q == 5'(TXN_PER_PKT));
  assign stop_normal = ack_seen_q || pkt_full || expired ||
                       (cur_q.byte_count == 16'h0000);
  assign stop_secure = pkt_full || expired ||
                       (cur_q.byte_count == 16'h0000);

  always_comb begin
    state_d     = state_q;
    cur_d       = cur_q;
    snap_d      = snap_q;
    txn_d       = txn_q;
    txn_valid_d = txn_valid_q && !txn_ready;
    rq_valid_d  = rq_valid_q;
    sent_d      = sent_q;
    ack_seen_d  = ack_seen_q;
    nack_d      = nack_q;
    done_d      = 1'b0;
    exhaust_d   = 1'b0;
    pkt_cnt_d   = pkt_cnt_q;
    if (ack_valid) begin
      ack_seen_d = 1'b1;
      nack_d     = nack_q || ack_is_nack;
    end
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          cur_d = desc;
          state_d = desc.remote ? ST_OPEN : ST_LOCAL;
        end
      end
      ST_OPEN: begin
        if (slot_free) begin
          txn_valid_d           = 1'b1;
          txn_d                 = '0;
          txn_d.kind            = TXN_OPEN;
          txn_d.dst_addr        = cur_q.dst_addr;
          snap_d                = cur_q;
          sent_d                = '0;
          ack_seen_d            = 1'b0;
          nack_d                = 1'b0;
          state_d               = ST_SEND;
        end
      end
      ST_SEND: begin
        if (cur_q.secure ? stop_secure : stop_normal) begin
          state_d = cur_q.secure ? ST_NULL : ST_WAIT;
        end else if (slot_free) begin
          txn_valid_d      = 1'b1;
          txn_d            = '0;
          txn_d.kind       = TXN_BLOCK;
          txn_d.ack_request_flag = !cur_q.secure &&
                                   (sent_q == 5'h00);
          txn_d.len        = chunk;
          txn_d.src_addr   = cur_q.src_addr;
          txn_d.dst_addr   = cur_q.dst_addr;
          cur_d.src_addr   = cur_q.src_addr + 32'(chunk);
          cur_d.dst_addr   = cur_q.dst_addr + 32'(chunk);
          cur_d.byte_count = cur_q.byte_count - 16'(chunk);
          sent_d           = sent_q + 5'h01;
        end
      end
      ST_NULL: begin
        if (slot_free) begin
          txn_valid_d            = 1'b1;
          txn_d                  = '0;
          txn_d.kind             = TXN_NULL;
          txn_d.ack_request_flag = 1'b1;
          txn_d.dst_addr         = cur_q.dst_addr;
          state_d                = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // close waits for the acknowledge
        if (ack_seen_q) begin
          state_d = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (slot_free) begin
          txn_valid_d    = 1'b1;
          txn_d          = '0;
          txn_d.kind     = TXN_END;
          txn_d.dst_addr = cur_q.dst_addr;
          pkt_cnt_d      = pkt_cnt_q + 16'h0001;
          state_d        = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (nack_q) begin
          if (cur_q.fail_count == 8'h00) begin
            exhaust_d = 1'b1;
            state_d   = ST_IDLE;
          end else begin
            cur_d            = snap_q;
            cur_d.fail_count = cur_q.fail_count - 8'h01;
            rq_valid_d       = 1'b1;
            state_d          = ST_REQUEUE;
          end
        end else if (cur_q.byte_count == 16'h0000) begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end else if (expired) begin
          rq_valid_d = 1'b1;
          state_d    = ST_REQUEUE;
        end else begin
          state_d = ST_OPEN;
        end
      end
      ST_REQUEUE: begin
        if (requeue_ready) begin
          rq_valid_d = 1'b0;
          state_d    = ST_IDLE;
        end
      end
      ST_LOCAL: begin
        // done only once the last block has gone out
        if (cur_q.byte_count == 16'h0000) begin
          if (slot_free) begin
            done_d  = 1'b1;
            state_d = ST_IDLE;
          end
        end else if (expired) begin
          rq_valid_d = 1'b1;
          state_d    = ST_REQUEUE;
        end else if (slot_free) begin
          txn_valid_d      = 1'b1;
          txn_d            = '0;
          txn_d.kind       = TXN_BLOCK;
          txn_d.local_copy = 1'b1;
          txn_d.len        = chunk;
          txn_d.src_addr   = cur_q.src_addr;
          txn_d.dst_addr   = cur_q.dst_addr;
          cur_d.src_addr   = cur_q.src_addr + 32'(chunk);
          cur_d.dst_addr   = cur_q.dst_addr + 32'(chunk);
          cur_d.byte_count = cur_q.byte_count - 16'(chunk);
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      cur_q       <= '0;
      snap_q      <= '0;
      txn_q       <= '0;
      txn_valid_q <= 1'b0;
      rq_valid_q  <= 1'b0;
      sent_q      <= '0;
      ack_seen_q  <= 1'b0;
      nack_q      <= 1'b0;
      done_q      <= 1'b0;
      exhaust_q   <= 1'b0;
      pkt_cnt_q   <= '0;
    end else begin
      state_q     <= state_d;
      cur_q       <= cur_d;
      snap_q      <= snap_d;
      txn_q       <= txn_d;
      txn_valid_q <= txn_valid_d;
      rq_valid_q  <= rq_valid_d;
      sent_q      <= sent_d;
      ack_seen_q  <= ack_seen_d;
      nack_q      <= nack_d;
      done_q      <= done_d;
      exhaust_q   <= exhaust_d;
      pkt_cnt_q   <= pkt_cnt_d;
    end
  end

  assign desc_ready    = take;
  assign txn_valid     = txn_valid_q;
  assign txn           = txn_q;
  assign requeue_valid = rq_valid_q;
  assign requeue_desc  = cur_q;
  assign desc_done     = done_q;

  // apb register file
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign hit    = (paddr == REG_CTRL_OFS) || (paddr == REG_STATUS_OFS) ||
                  (paddr == REG_MASK_OFS) || (paddr == REG_STATE_OFS) ||
                  (paddr == REG_COUNT_OFS);
  assign status_rd = access && !pwrite && (paddr == REG_STATUS_OFS);

  always_comb begin
    enable_d = enable_q;
    mask_d   = mask_q;
    rdata_d  = rdata_q;
    if (access && pwrite && (paddr == REG_CTRL_OFS)) begin
      enable_d = pwdata[CTRL_ENABLE_BIT];
    end
    if (access && pwrite && (paddr == REG_MASK_OFS)) begin
      mask_d = pwdata[7:0];
    end
    if (setup) begin
      case (paddr)
        REG_CTRL_OFS:   rdata_d = {31'h0, enable_q};
        REG_STATUS_OFS: rdata_d = {24'h0, status};
        REG_MASK_OFS:   rdata_d = {24'h0, mask_q};
        REG_STATE_OFS:  rdata_d = {11'h0, sent_q, cur_q.fail_count,
                                   4'h0, state_q};
        REG_COUNT_OFS:  rdata_d = {16'h0, pkt_cnt_q};
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q <= CTRL_RESET_VAL;
      mask_q   <= MASK_RESET_VAL;
      rdata_q  <= '0;
    end else begin
      enable_q <= enable_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
endmodule : dpr_engine

// File: bench/dpr_checker.sv
`timescale 1ns/1ps
module dpr_checker
  import dpr_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         sys_rst,
  // descriptor side
  input wire logic         desc_valid,
  input wire logic         desc_ready,
  input wire dpr_desc_type desc,
  input wire logic         requeue_valid,
  input wire dpr_desc_type requeue_desc,
  // outputter side
  input wire logic         txn_valid,
  input wire logic         txn_ready,
  input wire dpr_txn_type  txn,
  input wire logic         ack_valid
);
  logic       sec_q, sec_d, seen_q, seen_d, acc;
  logic [7:0] fail_q, fail_d;
  logic [4:0] blk_q, blk_d;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // mode and fail count of the taken descriptor, blocks of the open packet
  always_comb begin
    acc = txn_valid && txn_ready;
    sec_d = sec_q;
    fail_d = fail_q;
    blk_d = blk_q;
    seen_d = seen_q || ack_valid;
    if (desc_valid && desc_ready) begin
      sec_d = desc.secure;
      fail_d = desc.fail_count;
    end
    if (acc && txn.kind == TXN_OPEN) begin
      blk_d = 5'h00;
      seen_d = 1'b0;
    end else if (acc && txn.kind == TXN_BLOCK && !txn.local_copy) begin
      blk_d = blk_q + 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sec_q <= 1'b0;
      seen_q <= 1'b0;
      fail_q <= 8'h00;
      blk_q <= 5'h00;
    end else begin
      sec_q <= sec_d;
      seen_q <= seen_d;
      fail_q <= fail_d;
      blk_q <= blk_d;
    end
  end
  AST_TAKE_VALID: assert property (desc_ready |-> desc_valid)
    else $error("descriptor taken without valid");
  AST_TXN_HOLD: assert property (txn_valid && !txn_ready |=> txn_valid && $stable(txn))
    else $error("transaction dropped or changed before accept");
  AST_LEN_MAX: assert property (txn_valid && txn.kind == TXN_BLOCK |-> txn.len <= 6'h20)
    else $error("block payload above limit");
  AST_PKT_BLOCKS: assert property (blk_q <= 5'h10)
    else $error("too many blocks in one packet");
  AST_FLAG_FIRST: assert property (
    txn_valid && txn.kind == TXN_BLOCK && !txn.local_copy
    |-> txn.ack_request_flag == (!sec_q && blk_q == 5'h00))
    else $error("ack request flag wrong on block");
  AST_NULL_FLAG: assert property (txn_valid && txn.kind == TXN_NULL |-> txn.ack_request_flag)
    else $error("null transaction without ack request");
  AST_LOCAL_BLOCK: assert property (txn_valid && txn.local_copy |-> txn.kind == TXN_BLOCK)
    else $error("local copy emitted packet framing");
  AST_END_ACK: assert property (txn_valid && txn.kind == TXN_END |-> seen_q)
    else $error("packet end before acknowledge");
  AST_RQ_FAIL: assert property ($rose(requeue_valid) |->
    requeue_desc.fail_count <= fail_q && {1'b0, requeue_desc.fail_count} + 9'h001 >= {1'b0, fail_q})
    else $error("requeued fail count not kept or decremented by one");
endmodule : dpr_checker

bind dpr_engine dpr_checker u_chk (
  .clk, .sys_rst, .desc_valid, .desc_ready, .desc, .requeue_valid, .requeue_desc,
  .txn_valid, .txn_ready, .txn, .ack_valid
);

// File: bench/dpr_net_model.sv
`timescale 1ns/1ps
module dpr_net_model
  import dpr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // outputter side
  input  wire logic        txn_valid,
  input  wire dpr_txn_type txn,
  output logic             txn_ready,
  output logic             ack_valid,
  output logic             ack_is_nack,
  // bench control
  input  wire logic        corrupt,
  input  wire logic [11:0] ack_delay
);
  logic [11:0] wait_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      txn_ready <= 1'b0;
      ack_valid <= 1'b0;
      ack_is_nack <= 1'b0;
      wait_q <= 12'h000;
    end else begin
      txn_ready <= ($urandom % 4) != 0;
      ack_valid <= 1'b0;
      // released line toggles every cycle while no answer is given
      ack_is_nack <= ~ack_is_nack;
      if (txn_valid && txn_ready && txn.ack_request_flag && !txn.local_copy) begin
        wait_q <= ack_delay;
      end else if (wait_q == 12'h001) begin
        ack_valid <= 1'b1;
        ack_is_nack <= corrupt;
        wait_q <= 12'h000;
      end else if (wait_q != 12'h000) begin
        wait_q <= wait_q - 12'h001;
      end
    end
  end
endmodule : dpr_net_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import dpr_pkg::*;
;
  localparam int TS = 2000;
  logic         clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic         desc_valid = 1'b0, requeue_ready = 1'b0, corrupt = 1'b0;
  logic [11:0]  paddr = 12'h000, ack_delay = 12'h001;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic [6:0]   exc_event = 7'h00;
  logic [7:0]   m;
  logic         pready, pslverr, desc_ready, requeue_valid, txn_valid, txn_ready;
  logic         ack_valid, ack_is_nack, desc_done, irq, err, done_seen, rq_seen;
  dpr_desc_type desc = '0, requeue_desc, rq, d;
  dpr_txn_type  txn;
  int           n_errors = 0, num_checks = 0, cyc = 0, bytes, nulls, ends = 0;

  initial forever #4 clk = ~clk;

  dpr_engine #(.TIMESLICE_CYC(TS)) uut (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .desc_valid, .desc, .desc_ready, .requeue_valid, .requeue_desc, .requeue_ready,
    .txn_valid, .txn, .txn_ready, .ack_valid, .ack_is_nack, .exc_event, .desc_done, .irq
  );
  dpr_net_model u_net (
    .clk, .sys_rst, .txn_valid, .txn, .txn_ready, .ack_valid, .ack_is_nack, .corrupt,
    .ack_delay
  );

  // queue tail stalls at random; monitor tallies traffic
  always @(posedge clk) begin
    requeue_ready <= 1'($urandom % 2);
    cyc++;
    if (desc_done) done_seen = 1'b1;
    if (requeue_valid && requeue_ready) begin
      rq_seen = 1'b1;
      rq = requeue_desc;
    end
    if (txn_valid && txn_ready && txn.kind == TXN_BLOCK) bytes += int'(txn.len);
    if (txn_valid && txn_ready && txn.kind == TXN_NULL) nulls++;
    if (txn_valid && txn_ready && txn.kind == TXN_END) ends++;
    if (cyc == 90000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic run(input dpr_desc_type dd);
    done_seen = 1'b0;
    rq_seen = 1'b0;
    bytes = 0;
    nulls = 0;
    desc <= dd;
    desc_valid <= 1'b1;
    do @(negedge clk); while (desc_ready !== 1'b1);
    @(posedge clk);
    desc_valid <= 1'b0;
    for (int k = 0; k < 20000 && !(done_seen || rq_seen || irq === 1'b1); k++) @(negedge clk);
    // a descriptor that never finishes ends the run
    if (!(done_seen || rq_seen || irq === 1'b1)) begin
      n_errors++;
      summarize();
    end
    @(posedge clk);
  endtask : run

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    void'($urandom(91));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    desc_valid <= 1'b1;
    apb(1'b0, REG_CTRL_OFS, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, REG_MASK_OFS, 32'h0);
    check("mask reset", rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped read", {rd[30:0], err}, 32'h1);
    apb(1'b0, REG_STATE_OFS, 32'h0);
    check("state reset", rd, 32'h0);
    apb(1'b0, REG_COUNT_OFS, 32'h0);
    check("count reset", rd, 32'h0);
    check("idle while disabled", {desc_ready, txn_valid, pready}, 32'h1);
    desc_valid <= 1'b0;
    apb(1'b1, REG_CTRL_OFS, 32'h1);
    for (int i = 0; i < 7; i++) begin
      m = 8'($urandom);
      apb(1'b1, REG_MASK_OFS, {24'h0, m});
      exc_event <= 7'(1 << i);
      @(posedge clk);
      exc_event <= 7'h00;
      repeat (3) @(negedge clk);
      check("irq under mask", irq, m[i]);
      @(posedge clk);
      apb(1'b0, REG_STATUS_OFS, 32'h0);
      check("status set", rd, 32'h1 << i);
      apb(1'b0, REG_STATUS_OFS, 32'h0);
      @(negedge clk);
      check("status cleared", {rd[31:1], irq}, 32'h0);
      @(posedge clk);
    end
    apb(1'b1, REG_MASK_OFS, 32'h0000_00FF);
    for (int i = 0; i < 6; i++) begin
      d = '0;
      d.remote = (i % 3) != 2;
      d.secure = (i % 3) == 1 || i == 5;
      d.fail_count = 8'h03;
      d.byte_count = 16'(33 + $urandom % 1000);
      d.src_addr = $urandom & 32'hFFFF_FFE0;
      d.dst_addr = $urandom & 32'hFFFF_FFE0;
      ack_delay <= 12'(1 + $urandom % 40);
      run(d);
      check("bytes moved", 32'(bytes), 32'(d.byte_count));
      check("nulls", 32'(nulls), (d.secure && d.remote) ? (32'(d.byte_count) + 511) / 512 : 0);
      check("completed", {rq_seen, done_seen}, 32'h1);
    end
    corrupt <= 1'b1;
    d.remote = 1'b1;
    d.secure = 1'b0;
    d.fail_count = 8'h01;
    d.byte_count = 16'h0064;
    run(d);
    check("nack requeue", {rq_seen, rq.fail_count, rq.byte_count}, {1'b1, 8'h00, 16'h0064});
    check("retry start", rq.src_addr, d.src_addr);
    run(rq);
    check("retry exhausted", {rq_seen, irq}, 32'h1);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    check("fault bit", rd, 32'h80);
    corrupt <= 1'b0;
    ack_delay <= 12'(TS + 100);
    d.fail_count = 8'h05;
    d.byte_count = 16'h0800;
    run(d);
    check("expiry requeue", {rq_seen, rq.fail_count, rq.byte_count}, {1'b1, 8'h05, 16'h0600});
    check("expiry progress", rq.src_addr, d.src_addr + 32'h200);
    repeat (8) @(posedge clk);
    apb(1'b0, REG_COUNT_OFS, 32'h0);
    check("packets closed", rd, 32'(ends));
    summarize();
  end
endmodule : tb_top
